// ---- hdl/cmd_pin_pkg.sv ----
// Package with constants and types for the command pin decoder
`default_nettype none
package cmd_pin_pkg;
	localparam int ADDR_W = 14;
	localparam int ROW_W = 17;
	localparam int OP_W = 18;
	localparam int BANKS = 16;
	localparam int AUTO_CLOSE_POS = 10;
	localparam int BURST_CUT_POS = 12;
	localparam int MR1_TERM_EN_POS = 0;
	localparam int MR1_TSTROBE_POS = 11;
	localparam int MR5_DM_POS = 10;
	localparam int MR5_WDBI_POS = 11;
	localparam int MR5_RDBI_POS = 12;
	localparam logic [2:0] MR_ONE = 3'h1;
	localparam logic [2:0] MR_FIVE = 3'h5;
	localparam logic [ADDR_W-1:0] MR1_RESET = 14'h0001;
	localparam logic [ADDR_W-1:0] MR5_RESET = 14'h0000;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;

	typedef enum logic [2:0] {
		op_none, op_act, op_rd, op_wr, op_pre, op_mrs, op_ref, op_other
	} cmd_op_t;

	typedef enum {
		pw_active, pw_pre_pd, pw_act_pd, pw_self_ref
	} power_state_t;

	typedef struct packed {
		cmd_op_t op;
		logic [1:0] group;
		logic [1:0] bank;
		logic [ROW_W-1:0] row;
		logic [ADDR_W-1:0] addr;
		logic auto_close;
		logic close_all;
		logic full_burst;
	} cmd_t;

	typedef struct packed {
		logic mask_en;
		logic wr_invert_en;
		logic rd_invert_en;
		logic term_en;
		logic strobe_en;
	} cfg_t;
endpackage
`default_nettype wire

// ---- hdl/cmd_pin_decode.sv ----
// Command, address and control pin decoder with power state tracking
// How it works
// - Sample pins on rising clock edge
// - Chip select high masks command
// - Clock gate low disables buffers, drivers
// - Gate low enters power-down or self-refresh
// - Self-refresh exit from sampled gate input
// - Self-refresh disables all inputs except gate, reset and read data
// - Termination input high applies nominal termination
// - Termination input ignored when disabled
// - Activate low gives row bits 16, 15, 14
// - Activate high means pins form command
// - Mask low discards write beat
// - Mode five bits choose mask or invert
// - Inversion low means data inverted
// - Group inputs select group; upper by-eight
// - Mode set uses group0, banks for register
// - Bank inputs select bank within group
// - Address carries row, column or opcode
// - Bit ten high requests auto precharge
// - Precharge bit ten high closes all
// - Burst cut bit low chops burst
// - Reset asynchronous, active low, held high; code syncs it through two flops and resets synchronously
`default_nettype none
module cmd_pin_decode
	import cmd_pin_pkg::*;
#(
	parameter bit BY_EIGHT = 1'b1,
	parameter int BEATS_W = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic clk_gate_in,
	input wire logic chip_sel_n,
	input wire logic activate_n,
	input wire logic row_strobe_addr16,
	input wire logic column_strobe_addr15,
	input wire logic write_strobe_addr14,
	input wire logic group_sel0,
	input wire logic group_sel1,
	input wire logic bank_sel0,
	input wire logic bank_sel1,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic termination_ctrl_in,
	input wire logic [BEATS_W-1:0] wr_data_in,
	input wire logic write_mask,
	input wire logic bus_invert,
	input wire logic wr_beat_valid,
	input wire logic [BEATS_W-1:0] rd_data_in,
	input wire logic rd_invert_req,
	output cmd_t cmd_out,
	output logic cmd_valid,
	output cfg_t cfg_out,
	output logic [BANKS-1:0] bank_open,
	output logic clocks_on,
	output logic inputs_on,
	output logic drivers_on,
	output logic self_refresh,
	output logic act_power_down,
	output logic pre_power_down,
	output logic nominal_termination,
	output logic termination_strobe,
	output logic [BEATS_W-1:0] wr_data_out,
	output logic wr_data_valid,
	output logic [BEATS_W-1:0] rd_data_out,
	output logic rd_bus_invert
);
	logic rst_meta_q;
	logic rst_sync_q;
	logic int_rst;
	logic gate_meta_q;
	logic gate_q;
	logic cs_n_q;
	logic act_n_q;
	logic ras_q;
	logic cas_q;
	logic we_q;
	logic g0_q;
	logic g1_q;
	logic b0_q;
	logic b1_q;
	logic term_q;
	logic mask_q;
	logic inv_q;
	logic beat_q;
	logic [ADDR_W-1:0] addr_q;
	logic [BEATS_W-1:0] wdata_q;
	logic [ADDR_W-1:0] mr1_q;
	logic [ADDR_W-1:0] mr5_q;
	logic [BANKS-1:0] open_q;
	power_state_t pw_q;
	power_state_t pw_d;
	cmd_t cmd_d;
	cmd_t cmd_q;
	logic valid_d;
	logic valid_q;
	logic [3:0] bank_idx;
	logic [2:0] cmd_code;
	logic [2:0] mr_sel;
	logic in_en;
	logic [BEATS_W-1:0] wdata_d;
	logic [BEATS_W-1:0] rdata_q;
	logic wvalid_q;
	logic rinv_q;

	// Pin reset released through two flops
	always_ff @(posedge core_clk) begin
		rst_meta_q <= reset_pin_n;
		rst_sync_q <= rst_meta_q;
	end
	assign int_rst = rst | ~rst_sync_q;

	// Gate input synchroniser
	always_ff @(posedge core_clk) begin
		gate_meta_q <= clk_gate_in;
		gate_q <= gate_meta_q;
	end

	assign in_en = gate_q && pw_q != pw_self_ref;

	// Capture command and address pins on the rising clock edge
	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			cs_n_q <= 1'b1;
			act_n_q <= 1'b1;
			ras_q <= 1'b1;
			cas_q <= 1'b1;
			we_q <= 1'b1;
			g0_q <= 1'b0;
			g1_q <= 1'b0;
			b0_q <= 1'b0;
			b1_q <= 1'b0;
			addr_q <= '0;
		end else if (in_en) begin
			cs_n_q <= chip_sel_n;
			act_n_q <= activate_n;
			ras_q <= row_strobe_addr16;
			cas_q <= column_strobe_addr15;
			we_q <= write_strobe_addr14;
			g0_q <= group_sel0;
			g1_q <= BY_EIGHT ? group_sel1 : 1'b0;
			b0_q <= bank_sel0;
			b1_q <= bank_sel1;
			addr_q <= addr_in;
		end else begin
			cs_n_q <= 1'b1;
		end
	end

	// Termination request, ignored while inputs are off
	always_ff @(posedge core_clk) begin
		if (int_rst)
			term_q <= 1'b0;
		else if (in_en)
			term_q <= termination_ctrl_in;
	end

	// Write beat with its mask and inversion pins
	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			mask_q <= 1'b1;
			inv_q <= 1'b1;
			beat_q <= 1'b0;
			wdata_q <= '0;
		end else if (in_en) begin
			mask_q <= write_mask;
			inv_q <= bus_invert;
			beat_q <= wr_beat_valid;
			wdata_q <= wr_data_in;
		end else begin
			beat_q <= 1'b0;
		end
	end

	assign cmd_code = {ras_q, cas_q, we_q};
	assign bank_idx = {g1_q, g0_q, b1_q, b0_q};
	assign mr_sel = {g0_q, b1_q, b0_q};

	// Command decode
	always_comb begin
		cmd_d = '0;
		valid_d = 1'b0;
		cmd_d.group = {g1_q, g0_q};
		cmd_d.bank = {b1_q, b0_q};
		cmd_d.addr = addr_q;
		cmd_d.row = {ras_q, cas_q, we_q, addr_q};
		cmd_d.auto_close = addr_q[AUTO_CLOSE_POS];
		cmd_d.close_all = addr_q[AUTO_CLOSE_POS];
		cmd_d.full_burst = addr_q[BURST_CUT_POS];
		cmd_d.op = op_none;
		if (!cs_n_q) begin
			valid_d = 1'b1;
			if (!act_n_q) begin
				cmd_d.op = op_act;
			end else begin
				case (cmd_code)
					CMD_MRS: cmd_d.op = op_mrs;
					CMD_REF: cmd_d.op = op_ref;
					CMD_PRE: cmd_d.op = op_pre;
					CMD_WR: cmd_d.op = op_wr;
					CMD_RD: cmd_d.op = op_rd;
					CMD_NOP: begin
						cmd_d.op = op_none;
						valid_d = 1'b0;
					end
					default: cmd_d.op = op_other;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			cmd_q <= '0;
			valid_q <= 1'b0;
		end else begin
			cmd_q <= cmd_d;
			valid_q <= valid_d;
		end
	end

	// Mode registers written by mode set
	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			mr1_q <= MR1_RESET;
			mr5_q <= MR5_RESET;
		end else if (valid_d && cmd_d.op == op_mrs) begin
			if (mr_sel == MR_ONE)
				mr1_q <= addr_q;
			if (mr_sel == MR_FIVE)
				mr5_q <= addr_q;
		end
	end

	// Open row tracking, one flop per bank
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		logic hit;
		logic open_set;
		logic open_clr;
		assign hit = bank_idx == 4'(b);
		assign open_set = valid_d && cmd_d.op == op_act && hit;
		assign open_clr = valid_d &&
			((cmd_d.op == op_pre && (cmd_d.close_all || hit)) ||
			((cmd_d.op == op_rd || cmd_d.op == op_wr) &&
			cmd_d.auto_close && hit));
		always_ff @(posedge core_clk) begin
			if (int_rst)
				open_q[b] <= 1'b0;
			else if (open_set)
				open_q[b] <= 1'b1;
			else if (open_clr)
				open_q[b] <= 1'b0;
		end
	end

	// Power state
	always_comb begin
		pw_d = pw_q;
		case (pw_q)
			pw_active: begin
				if (!gate_q) begin
					if (|open_q)
						pw_d = pw_act_pd;
					else if (valid_q && cmd_q.op == op_ref)
						pw_d = pw_self_ref;
					else
						pw_d = pw_pre_pd;
				end
			end
			pw_pre_pd, pw_act_pd, pw_self_ref: begin
				if (gate_q)
					pw_d = pw_active;
			end
			default: pw_d = pw_active;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (int_rst)
			pw_q <= pw_active;
		else
			pw_q <= pw_d;
	end

	// Data path: mask and inversion
	always_comb begin
		wdata_d = wdata_q;
		if (cfg_out.wr_invert_en && !inv_q)
			wdata_d = ~wdata_q;
	end

	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			wr_data_out <= '0;
			wvalid_q <= 1'b0;
		end else begin
			wr_data_out <= wdata_d;
			wvalid_q <= beat_q && !(cfg_out.mask_en && !mask_q);
		end
	end

	// Read data, inverted on request when read inversion is on
	always_ff @(posedge core_clk) begin
		if (int_rst) begin
			rdata_q <= '0;
			rinv_q <= 1'b1;
		end else if (cfg_out.rd_invert_en && rd_invert_req) begin
			rdata_q <= ~rd_data_in;
			rinv_q <= 1'b0;
		end else begin
			rdata_q <= rd_data_in;
			rinv_q <= 1'b1;
		end
	end

	assign cfg_out.mask_en = mr5_q[MR5_DM_POS];
	assign cfg_out.wr_invert_en = mr5_q[MR5_WDBI_POS];
	assign cfg_out.rd_invert_en = mr5_q[MR5_RDBI_POS];
	assign cfg_out.term_en = mr1_q[MR1_TERM_EN_POS];
	assign cfg_out.strobe_en = BY_EIGHT & mr1_q[MR1_TSTROBE_POS];

	assign cmd_out = cmd_q;
	assign cmd_valid = valid_q;
	assign bank_open = open_q;
	assign clocks_on = gate_q;
	assign inputs_on = in_en;
	assign drivers_on = gate_q;
	assign self_refresh = pw_q == pw_self_ref;
	assign act_power_down = pw_q == pw_act_pd;
	assign pre_power_down = pw_q == pw_pre_pd;
	assign nominal_termination = term_q & cfg_out.term_en;
	assign termination_strobe = nominal_termination & cfg_out.strobe_en;
	assign wr_data_valid = wvalid_q;
	assign rd_data_out = rdata_q;
	assign rd_bus_invert = rinv_q;
endmodule
`default_nettype wire

// ---- dv/ctrl_model.sv ----
// Controller model driving command, address and control pins
`default_nettype none
module ctrl_model (
	input wire logic [22:0] req,
	input wire logic gate_req,
	input wire logic rst_req_n,
	output logic chip_sel_n,
	output logic activate_n,
	output logic row_strobe_addr16,
	output logic column_strobe_addr15,
	output logic write_strobe_addr14,
	output logic group_sel1,
	output logic group_sel0,
	output logic bank_sel1,
	output logic bank_sel0,
	output logic [13:0] addr_in,
	output logic clk_gate_in,
	output logic reset_pin_n
);
	assign {chip_sel_n, activate_n, row_strobe_addr16, column_strobe_addr15,
		write_strobe_addr14, group_sel1, group_sel0, bank_sel1, bank_sel0,
		addr_in} = req;
	// Gate forced high whenever a read or write is on the pins
	assign clk_gate_in = gate_req | (!chip_sel_n && activate_n &&
		row_strobe_addr16 && !column_strobe_addr15);
	assign reset_pin_n = rst_req_n;
endmodule
`default_nettype wire

// ---- dv/cmd_pin_checker.sv ----
// Assertion checker for the command pin decoder
`default_nettype none
module cmd_pin_checker
	import cmd_pin_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic clk_gate_in,
	input wire logic chip_sel_n,
	input wire logic column_strobe_addr15,
	input wire logic write_strobe_addr14,
	input wire cmd_t cmd_out,
	input wire logic cmd_valid,
	input wire cfg_t cfg_out,
	input wire logic [BANKS-1:0] bank_open,
	input wire logic clocks_on,
	input wire logic drivers_on,
	input wire logic inputs_on,
	input wire logic self_refresh,
	input wire logic act_power_down,
	input wire logic pre_power_down,
	input wire logic nominal_termination,
	input wire logic termination_strobe
);
	logic [7:0] pin_rst_q;
	wire logic [1:0] row_hi = {column_strobe_addr15, write_strobe_addr14};
	always_ff @(posedge core_clk) begin
		pin_rst_q <= {pin_rst_q[6:0], ~reset_pin_n};
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst || !reset_pin_n || (|pin_rst_q));
	sequence gate_off_s; !clk_gate_in [*3]; endsequence
	sequence gate_on_s; clk_gate_in [*5]; endsequence
	AST_CS_MASK: assert property (cmd_valid |->
		!$past(chip_sel_n) || !$past(chip_sel_n, 2))
		else $error("Command taken with chip select high");
	AST_ACT_ROW: assert property (cmd_valid && cmd_out.op == op_act |->
		cmd_out.row[15:14] == $past(row_hi) ||
		cmd_out.row[15:14] == $past(row_hi, 2))
		else $error("Activate row bits wrong");
	AST_GATE_OFF: assert property (gate_off_s |->
		!clocks_on && !drivers_on) else $error("Clocks on with gate low");
	AST_GATE_ON: assert property (gate_on_s |-> clocks_on)
		else $error("Clocks off with gate high");
	AST_SR_IN: assert property (self_refresh |-> !inputs_on)
		else $error("Inputs on in self refresh");
	AST_SR_EXIT: assert property (self_refresh ##1 gate_on_s |->
		!self_refresh) else $error("Self refresh not left");
	AST_APD: assert property ($rose(act_power_down) |->
		$past(bank_open) != '0) else $error("Active power-down, no row");
	AST_PPD: assert property ($rose(pre_power_down) |->
		$past(bank_open) == '0) else $error("Precharge power-down, row open");
	AST_NOTERM: assert property (nominal_termination |->
		cfg_out.term_en || $past(cfg_out.term_en))
		else $error("Termination while disabled");
	AST_TSTR: assert property (termination_strobe |->
		cfg_out.strobe_en || $past(cfg_out.strobe_en))
		else $error("Strobe termination while disabled");
endmodule
bind cmd_pin_decode cmd_pin_checker cmd_pin_checker_i (.*);
`default_nettype wire

// ---- dv/test_cmd_pin_decode.sv ----
// Testbench for the command pin decoder
`default_nettype none
module test_cmd_pin_decode
	import cmd_pin_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed { logic [22:0] pins; cmd_op_t op; } row_t;
	localparam logic [22:0] IDLE = 23'h7c0000;
	row_t rows [10] = '{'{23'h1b5234, op_act}, '{23'h334400, op_wr},
		'{23'h361000, op_rd}, '{23'h2b4000, op_pre}, '{23'h240000, op_ref},
		'{23'h2c0000, op_other}, '{23'h204800, op_mrs},
		'{23'h215c00, op_mrs}, '{23'h761000, op_none},
		'{23'h3c0000, op_none}};
	logic core_clk, rst, gate_req, rst_req_n, termination_ctrl_in;
	logic write_mask, bus_invert, wr_beat_valid, rd_invert_req;
	logic [22:0] req;
	logic [7:0] wr_data_in, rd_data_in, wr_data_out, rd_data_out, d;
	wire reset_pin_n, clk_gate_in, chip_sel_n, activate_n;
	wire row_strobe_addr16, column_strobe_addr15, write_strobe_addr14;
	wire group_sel0, group_sel1, bank_sel0, bank_sel1;
	wire [13:0] addr_in;
	cmd_t cmd_out, got;
	cfg_t cfg_out;
	logic [15:0] bank_open;
	logic cmd_valid, clocks_on, inputs_on, drivers_on, self_refresh;
	logic act_power_down, pre_power_down, nominal_termination;
	logic termination_strobe, wr_data_valid, rd_bus_invert;
	int error_cnt = 0;
	int checks_done = 0;
	int v;
	ctrl_model ctrl_model_i (.*);
	cmd_pin_decode cmd_pin_decode_i (.*);
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic send(input row_t r);
		req = r.pins;
		tick(1);
		req = IDLE;
		got = '0;
		repeat (4) begin
			tick(1);
			if (cmd_valid === 1'b1 && got.op === op_none)
				got = cmd_out;
		end
		chk("op", got.op, r.op);
		if (r.op inside {op_act, op_rd, op_wr, op_pre})
			chk("bank", {got.group, got.bank}, r.pins[17:14]);
		if (r.op == op_act)
			chk("row", got.row, {r.pins[20:18], r.pins[13:0]});
		if (r.op inside {op_rd, op_wr}) begin
			chk("addr", got.addr, r.pins[13:0]);
			chk("ap", got.auto_close, r.pins[10]);
			chk("bc", got.full_burst, r.pins[12]);
		end
		if (r.op == op_pre)
			chk("all", got.close_all, r.pins[10]);
	endtask
	task automatic final_report;
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		#10000;
		error_cnt++;
		final_report;
	end
	initial begin
		{rst, rst_req_n, gate_req, termination_ctrl_in} = 4'hf;
		{write_mask, bus_invert, wr_beat_valid, rd_invert_req} = 4'hc;
		req = IDLE;
		wr_data_in = 8'h3c;
		rd_data_in = 8'h0f;
		tick(10);
		rst = 0;
		tick(4);
		chk("term", nominal_termination, 1);
		foreach (rows[i]) send(rows[i]);
		chk("term", nominal_termination, 0);
		chk("cfg", cfg_out, 5'h1d);
		chk("open", bank_open, 0);
		bus_invert = 0;
		v = 0;
		for (int n = 0; n < 6; n++) begin
			wr_beat_valid = (n < 2);
			write_mask = (n == 1);
			tick(1);
			if (wr_data_valid === 1'b1) begin
				v++;
				d = wr_data_out;
			end
		end
		chk("wv", v, 1);
		chk("wd", d, 8'hc3);
		rd_invert_req = 1;
		tick(3);
		chk("rd", {rd_bus_invert, rd_data_out}, 9'h0f0);
		send(rows[0]);
		gate_req = 0;
		tick(6);
		chk("apd", {act_power_down, clocks_on}, 2'h2);
		gate_req = 1;
		tick(6);
		chk("apd", act_power_down, 0);
		send(rows[3]);
		gate_req = 0;
		tick(6);
		chk("ppd", pre_power_down, 1);
		gate_req = 1;
		tick(6);
		req = rows[4].pins;
		gate_req = 0;
		tick(1);
		req = IDLE;
		tick(6);
		chk("sr", self_refresh, 1);
		chk("in", inputs_on, 0);
		gate_req = 1;
		tick(8);
		chk("in", inputs_on, 1);
		send(rows[0]);
		rst_req_n = 0;
		tick(4);
		rst_req_n = 1;
		tick(6);
		chk("prst", {cfg_out, bank_open}, 21'h020000);
		final_report;
	end
endmodule
`default_nettype wire
